// >>> rtl/ccp_output_steer_capture_gating.sv
module ccp_output_steer_capture_gating
#(
	parameter bit multi_output = 1'b1 // multi_output_variant
)
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        tb_rollover,
	input  wire logic        timer_mode,
	input  wire logic        mode_signal,
	input  wire logic        compare_event,
	input  wire logic [5:0]  waveform,
	input  wire logic        capture_input_pin,
	input  wire logic        comparator_1,
	input  wire logic        comparator_2,
	input  wire logic        logic_cell_1,
	input  wire logic        logic_cell_2,
	input  wire logic        gate_source,
	input  wire logic        capture_edge,
	input  wire logic [7:0]  shutdown_inputs,
	input  wire logic        shutdown_clear_sw,
	output logic [5:0]       compare_output_pin,
	output logic [5:0]       compare_output_oe_n,
	output logic             capture_event,
	output logic             capture_disable_flag,
	output logic             shutdown_event_flag,
	output logic             aux_out,
	output logic             irq
);
	// ------------------------------------------------------------
	// storage
	// ------------------------------------------------------------
	localparam int       ev_w = ccp_steer_pkg::ev_width; // event count
	logic [31:0]         ctrl_q;      // control 2 image
	logic [5:0]          steer_q;     // applied steering
	logic [5:0]          pend_q;      // steering awaiting rollover
	logic                pend_v_q;    // pending update present
	logic [ev_w-1:0]     ev_stat_q;   // sticky events
	logic [ev_w-1:0]     ev_en_q;     // event enables
	logic                gate_prev_q; // gating level last cycle
	logic                src_prev_q;  // capture input last cycle
	logic [5:0]          steer_mask;  // implemented enables
	logic [ev_w-1:0]     ev_now;      // events this cycle

	// ------------------------------------------------------------
	// synchronised pins
	// ------------------------------------------------------------
	logic [12:0] pins_s; // pin levels after two flops
	ccp_sync2 #(.width(13)) u_sync
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in ({shutdown_inputs, gate_source, logic_cell_2,
			logic_cell_1, comparator_2,
			comparator_1}),
		.sync_out (pins_s)
	);
	// pin for the remappable source sampled separately
	logic [0:0] cap_pin_s;
	ccp_sync2 #(.width(1)) u_sync_pin
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (capture_input_pin),
		.sync_out (cap_pin_s)
	);

	logic [7:0] shut_s; // synchronised shutdown sources
	logic       gate_s; // synchronised gating source
	assign shut_s = pins_s[12:5];
	assign gate_s = pins_s[4];

	// single-output parts keep only output a
	assign steer_mask = multi_output ? 6'h3f : 6'h01;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic logic hit(input logic [3:0] a);
		hit = reg_wr && (reg_addr == a);
	endfunction : hit

	logic [1:0] gmode;  // capture_gate_mode
	logic [2:0] srcsel; // capture_source_select
	logic [1:0] auxsel; // aux_out_select
	assign gmode  = ctrl_q[ccp_steer_pkg::gate_lsb +: 2];
	assign srcsel = ctrl_q[ccp_steer_pkg::src_lsb +: 3];
	assign auxsel = ctrl_q[ccp_steer_pkg::aux_lsb +: 2];

	// ------------------------------------------------------------
	// control register write
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= ccp_steer_pkg::ctrl2_reset;
		else if (hit(ccp_steer_pkg::ctrl2_off))
			// unimplemented bits held at zero
			ctrl_q <= reg_wdata & ccp_steer_pkg::ctrl2_wmask
				& {2'h3, steer_mask, 24'hffffff};
	end

	// ------------------------------------------------------------
	// steering update, immediate or at rollover
	// ------------------------------------------------------------
	logic [5:0] wr_steer; // steering bits of this write
	assign wr_steer = reg_wdata[ccp_steer_pkg::steer_lsb +: 6]
		& steer_mask;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			steer_q  <= 6'h01;
			pend_q   <= 6'h01;
			pend_v_q <= 1'b0;
		end
		else if (hit(ccp_steer_pkg::ctrl2_off))
		begin
			if (reg_wdata[ccp_steer_pkg::sync_bit])
			begin
				pend_q   <= wr_steer; // held for rollover
				pend_v_q <= 1'b1;
			end
			else
			begin
				steer_q  <= wr_steer; // applied at once
				pend_v_q <= 1'b0;
			end
		end
		else if (pend_v_q && tb_rollover)
		begin
			steer_q  <= pend_q; // time base reset or rollover
			pend_v_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// pin drive: owned pins carry waveform, others released
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			compare_output_pin  <= 6'h00;
			compare_output_oe_n <= 6'h3f;
		end
		else
		begin
			// shutdown forces owned pins low, still driven
			compare_output_pin  <= waveform & steer_q
				& {6{~shutdown_event_flag}};
			compare_output_oe_n <= ~steer_q;
		end
	end

	// ------------------------------------------------------------
	// capture source select
	// ------------------------------------------------------------
	logic cap_src; // selected capture level
	always_comb
	begin
		unique case (srcsel)
			ccp_steer_pkg::src_pin:   cap_src = cap_pin_s[0];
			ccp_steer_pkg::src_cmp1:  cap_src = pins_s[0];
			ccp_steer_pkg::src_cmp2:  cap_src = pins_s[1];
			ccp_steer_pkg::src_cell1: cap_src = pins_s[2];
			ccp_steer_pkg::src_cell2: cap_src = pins_s[3];
			default:                  cap_src = 1'b0; // reserved
		endcase
	end

	// ------------------------------------------------------------
	// capture gating
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			gate_prev_q          <= 1'b0;
			capture_disable_flag <= 1'b0;
		end
		else
		begin
			gate_prev_q <= gate_s;
			unique case (gmode)
				ccp_steer_pkg::gate_level:
					capture_disable_flag <= ~gate_s;
				ccp_steer_pkg::gate_rise:
					if (gate_s && !gate_prev_q)
						capture_disable_flag <= 1'b0;
				ccp_steer_pkg::gate_fall:
					if (!gate_s && gate_prev_q)
						capture_disable_flag <= 1'b1;
				default:
					; // reserved code keeps the flag
			endcase
		end
	end

	// ------------------------------------------------------------
	// capture event: selected edge while enabled
	// ------------------------------------------------------------
	// a source switch can look like an edge: switch while disabled
	logic cap_hit; // selected input edge
	assign cap_hit = (cap_src != src_prev_q) &&
		(cap_src == capture_edge);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			src_prev_q    <= 1'b0;
			capture_event <= 1'b0;
		end
		else
		begin
			src_prev_q    <= cap_src;
			capture_event <= cap_hit && !capture_disable_flag;
		end
	end

	// ------------------------------------------------------------
	// auto-shutdown and restart
	// ------------------------------------------------------------
	logic shut_any; // any enabled source active
	assign shut_any = |(shut_s & ctrl_q[ccp_steer_pkg::asdg_lsb +: 8])
		|| ctrl_q[ccp_steer_pkg::sw_shut_bit];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			shutdown_event_flag <= 1'b0;
		end
		else if (shut_any)
		begin
			// set wins over every clear
			shutdown_event_flag <= 1'b1;
		end
		else if (ctrl_q[ccp_steer_pkg::restart_bit])
		begin
			if (shutdown_event_flag && tb_rollover)
				shutdown_event_flag <= 1'b0; // next period
		end
		else if (shutdown_clear_sw)
			shutdown_event_flag <= 1'b0; // software only
	end

	// ------------------------------------------------------------
	// auxiliary output
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			aux_out <= 1'b0;
		else
		begin
			unique case (auxsel)
				ccp_steer_pkg::aux_off:   aux_out <= 1'b0;
				ccp_steer_pkg::aux_roll:  aux_out <= tb_rollover;
				ccp_steer_pkg::aux_mode:  aux_out <= mode_signal;
				ccp_steer_pkg::aux_event: aux_out <= !timer_mode &&
					(compare_event || capture_event);
			endcase
		end
	end

	// ------------------------------------------------------------
	// interrupt status, enable, clear
	// ------------------------------------------------------------
	always_comb
	begin
		ev_now = '0;
		ev_now[ccp_steer_pkg::ev_capture]  = capture_event;
		ev_now[ccp_steer_pkg::ev_shutdown] = shut_any &&
			!shutdown_event_flag;
		ev_now[ccp_steer_pkg::ev_restart]  = !shut_any &&
			ctrl_q[ccp_steer_pkg::restart_bit] &&
			shutdown_event_flag && tb_rollover;
		ev_now[ccp_steer_pkg::ev_steer]    = pend_v_q && tb_rollover &&
			!hit(ccp_steer_pkg::ctrl2_off);
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ev_stat_q <= '0;
			ev_en_q   <= '0;
		end
		else
		begin
			// new event wins over a clear in the same cycle
			if (hit(ccp_steer_pkg::irq_clear_off))
				ev_stat_q <= (ev_stat_q & ~reg_wdata[ev_w-1:0]) | ev_now;
			else
				ev_stat_q <= ev_stat_q | ev_now;
			if (hit(ccp_steer_pkg::irq_enable_off))
				ev_en_q <= reg_wdata[ev_w-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(ev_stat_q & ev_en_q);
	end

	// ------------------------------------------------------------
	// read port, data one cycle after strobe
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ccp_steer_pkg::ctrl2_off:       reg_rdata <= ctrl_q;
				ccp_steer_pkg::irq_status_off:
					reg_rdata <= {28'h0000000, ev_stat_q};
				ccp_steer_pkg::irq_enable_off:
					reg_rdata <= {28'h0000000, ev_en_q};
				ccp_steer_pkg::live_status_off:
					reg_rdata <= {21'h000000, shutdown_event_flag,
						capture_disable_flag, pend_v_q, steer_q, 2'h0};
				default:                         reg_rdata <= 32'h00000000;
			endcase
		end
		else
			reg_rdata <= 32'h00000000;
	end
endmodule : ccp_output_steer_capture_gating

// >>> rtl/ccp_steer_pkg.sv
package ccp_steer_pkg;
	// ------------------------------------------------------------
	// register offsets (plain port, word index)
	// ------------------------------------------------------------
	localparam logic [3:0] ctrl2_off       = 4'h0; // control 2
	localparam logic [3:0] irq_status_off  = 4'h1; // sticky events, ro
	localparam logic [3:0] irq_enable_off  = 4'h2; // event enables
	localparam logic [3:0] irq_clear_off   = 4'h3; // write one to clear
	localparam logic [3:0] live_status_off = 4'h4; // live steering state

	// ------------------------------------------------------------
	// control 2 field positions
	// ------------------------------------------------------------
	localparam int sync_bit      = 31; // output_enable_sync
	localparam int steer_lsb     = 24; // output_steer_enables 29:24
	localparam int gate_lsb      = 22; // capture_gate_mode 23:22
	localparam int aux_lsb       = 19; // aux_out_select 20:19
	localparam int src_lsb       = 16; // capture_source_select 18:16
	localparam int restart_bit   = 15; // pwm_auto_restart
	localparam int gate_mode_bit = 14; // shutdown gate mode bit
	localparam int sw_shut_bit   = 12; // software shutdown gate
	localparam int asdg_lsb      = 0;  // shutdown_gate_sources 7:0

	// writable mask: 30, 21, 13, 11:8 unimplemented
	localparam logic [31:0] ctrl2_wmask = 32'hbfdfd0ff;
	// output a steering enable set at reset
	localparam logic [31:0] ctrl2_reset = 32'h01000000;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] gate_level = 2'h0;
	localparam logic [1:0] gate_rise  = 2'h1;
	localparam logic [1:0] gate_fall  = 2'h2;
	localparam logic [1:0] aux_off    = 2'h0;
	localparam logic [1:0] aux_roll   = 2'h1;
	localparam logic [1:0] aux_mode   = 2'h2;
	localparam logic [1:0] aux_event  = 2'h3;
	localparam logic [2:0] src_pin    = 3'h0;
	localparam logic [2:0] src_cmp1   = 3'h1;
	localparam logic [2:0] src_cmp2   = 3'h2;
	localparam logic [2:0] src_cell1  = 3'h4;
	localparam logic [2:0] src_cell2  = 3'h5;

	// ------------------------------------------------------------
	// interrupt event bits
	// ------------------------------------------------------------
	localparam int ev_capture  = 0; // accepted capture
	localparam int ev_shutdown = 1; // shutdown event set
	localparam int ev_restart  = 2; // automatic restart
	localparam int ev_steer    = 3; // held steering applied at rollover
	localparam int ev_width    = 4;
endpackage : ccp_steer_pkg

// >>> rtl/ccp_sync2.sv
// ------------------------------------------------------------
// two-flop synchroniser for a bank of pin levels
// ------------------------------------------------------------
module ccp_sync2
#(
	parameter int width = 1
)
(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [width-1:0] async_in,
	output logic      [width-1:0] sync_out
);
	logic [width-1:0] meta_q; // first stage, read only by second

	// first and second stage
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : ccp_sync2

// >>> testbench/ccp_steer_monitor.sv
// ------------------------------------------------------------
// port checker: steering, gating, shutdown, read port
// ------------------------------------------------------------
module ccp_steer_monitor
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        tb_rollover,
	input wire logic        gate_source,
	input wire logic [7:0]  shutdown_inputs,
	input wire logic        shutdown_clear_sw,
	input wire logic [5:0]  compare_output_pin,
	input wire logic [5:0]  compare_output_oe_n,
	input wire logic        capture_event,
	input wire logic        capture_disable_flag,
	input wire logic        shutdown_event_flag
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ctl_wr; // control write taken
	logic ctl_rd; // control read taken
	assign ctl_wr = reg_wr && reg_addr == ccp_steer_pkg::ctrl2_off;
	assign ctl_rd = reg_rd && reg_addr == ccp_steer_pkg::ctrl2_off;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ------------------------------------------------------------
	// quiet spans long enough to cover the two-flop delay
	// ------------------------------------------------------------
	sequence sd_quiet;
		(shutdown_inputs == 8'h00) [*4];
	endsequence
	sequence gate_high;
		gate_source [*4];
	endsequence
	sequence gate_low;
		!gate_source [*4];
	endsequence

	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside its slot");
	reserved_bits_a: assert property (
		$past(ctl_rd) |-> reg_rdata[30] == 1'b0 && reg_rdata[21] == 1'b0)
		else $error("unimplemented control bit reads one");
	released_pins_a: assert property (
		(compare_output_pin & compare_output_oe_n) == 6'h00)
		else $error("released pin carries waveform");
	shut_pins_a: assert property (
		shutdown_event_flag && $past(shutdown_event_flag)
		|-> compare_output_pin == 6'h00)
		else $error("pin active during shutdown");
	steer_time_a: assert property (
		$changed(compare_output_oe_n) && $past(rst_n, 3)
		|-> $past(ctl_wr, 2) || $past(tb_rollover, 2))
		else $error("steering moved without write or rollover");
	capture_gate_a: assert property (
		capture_event |-> !$past(capture_disable_flag))
		else $error("capture while disabled");
	gate_set_a: assert property (
		gate_high |=> !$rose(capture_disable_flag))
		else $error("capture disabled with gate high");
	gate_clear_a: assert property (
		gate_low |=> !$fell(capture_disable_flag))
		else $error("capture enabled with gate low");
	shut_set_a: assert property (
		sd_quiet |=> !$rose(shutdown_event_flag))
		else $error("shutdown set with no source");
	shut_clear_a: assert property (
		$fell(shutdown_event_flag)
		|-> $past(tb_rollover) || $past(shutdown_clear_sw))
		else $error("shutdown cleared without cause");
endmodule : ccp_steer_monitor

bind ccp_output_steer_capture_gating ccp_steer_monitor mon
(
	.clk                  (clk),
	.rst_n                (rst_n),
	.reg_addr             (reg_addr),
	.reg_wr               (reg_wr),
	.reg_rd               (reg_rd),
	.reg_rdata            (reg_rdata),
	.tb_rollover          (tb_rollover),
	.gate_source          (gate_source),
	.shutdown_inputs      (shutdown_inputs),
	.shutdown_clear_sw    (shutdown_clear_sw),
	.compare_output_pin   (compare_output_pin),
	.compare_output_oe_n  (compare_output_oe_n),
	.capture_event        (capture_event),
	.capture_disable_flag (capture_disable_flag),
	.shutdown_event_flag  (shutdown_event_flag)
);

// >>> testbench/ccp_source_model.sv
// ------------------------------------------------------------
// capture sources: comparators, logic cells, capture pin
// ------------------------------------------------------------
module ccp_source_model
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [2:0] sel,   // source code the bench drives
	input wire logic       level, // level of that source
	output logic           capture_input_pin,
	output logic           comparator_1,
	output logic           comparator_2,
	output logic           logic_cell_1,
	output logic           logic_cell_2
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt_q; // free pattern for idle sources
	logic [5:0] src;   // one slot per source code

	// idle sources keep toggling, so a wrong pick shows up
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt_q <= 3'h0;
		else
			cnt_q <= cnt_q + 3'h1;
	always_comb
	begin
		src = {6{cnt_q[2]}};
		src[sel] = level;
	end
	assign capture_input_pin = src[0];
	assign comparator_1      = src[1];
	assign comparator_2      = src[2];
	assign logic_cell_1      = src[4];
	assign logic_cell_2      = src[5];
endmodule : ccp_source_model

// >>> testbench/ccp_output_steer_capture_gating_tb.sv
module ccp_output_steer_capture_gating_tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(nm, e, g) \
	begin checked++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end

	logic        clk, rst_n, reg_wr, reg_rd, tb_rollover, mode_signal;
	logic        compare_event, gate_source, shutdown_clear_sw, level;
	logic        timer_mode, cedge;
	logic        cin, cmp1, cmp2, cell1, cell2, capture_event, aux_out;
	logic        capture_disable_flag, shutdown_event_flag, irq, aux_p;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [5:0]  waveform, pins, oe_n;
	logic [7:0]  shutdown_inputs;
	logic [2:0]  sel;
	logic [2:0]  codes [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
	int          fails, checked, caps, auxn, n;

	ccp_output_steer_capture_gating uut (.clk(clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tb_rollover(tb_rollover),
		.timer_mode(timer_mode), .mode_signal(mode_signal),
		.compare_event(compare_event), .waveform(waveform),
		.capture_input_pin(cin), .comparator_1(cmp1), .comparator_2(cmp2),
		.logic_cell_1(cell1), .logic_cell_2(cell2),
		.gate_source(gate_source), .capture_edge(cedge),
		.shutdown_inputs(shutdown_inputs),
		.shutdown_clear_sw(shutdown_clear_sw), .compare_output_pin(pins),
		.compare_output_oe_n(oe_n), .capture_event(capture_event),
		.capture_disable_flag(capture_disable_flag),
		.shutdown_event_flag(shutdown_event_flag), .aux_out(aux_out),
		.irq(irq));
	ccp_source_model srcs (.clk(clk), .rst_n(rst_n), .sel(sel),
		.level(level), .capture_input_pin(cin), .comparator_1(cmp1),
		.comparator_2(cmp2), .logic_cell_1(cell1), .logic_cell_2(cell2));

	// ------------------------------------------------------------
	// clock, event counters, bus tasks
	// ------------------------------------------------------------
	always #25 clk = ~clk;
	// counts pulses; aux counted on rising level only
	always @(posedge clk)
	begin
		if (capture_event === 1'b1) caps++;
		if (aux_out === 1'b1 && aux_p !== 1'b1) auxn++;
		aux_p = aux_out;
	end
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data stand only in the cycle after the strobe
	task rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK("reg_rdata", e, reg_rdata)
	endtask : rd
	task roll;
		@(posedge clk) tb_rollover <= 1'b1;
		@(posedge clk) tb_rollover <= 1'b0;
	endtask : roll
	task gate(input logic g, input logic e);
		@(posedge clk) gate_source <= g;
		cyc(6);
		`CHK("capture_disable_flag", e, capture_disable_flag)
	endtask : gate
	task sd(input logic [7:0] v, input logic e);
		@(posedge clk) shutdown_inputs <= v;
		cyc(6);
		`CHK("shutdown_event_flag", e, shutdown_event_flag)
	endtask : sd
	task end_sim;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		{clk, rst_n, reg_wr, reg_rd, tb_rollover, mode_signal} = 6'h0;
		{timer_mode, compare_event, shutdown_clear_sw, level, sel} = 7'h0;
		{reg_addr, reg_wdata, shutdown_inputs} = 44'h0;
		{gate_source, cedge} = 2'h3;
		waveform = 6'h15;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		`CHK("oe_n", 6'h3e, oe_n)
		rd(4'h0, 32'h01000000);
		rd(4'hf, 32'h00000000);
		wr(4'h0, 32'hffffefff);
		rd(4'h0, 32'hbfdfc0ff);
		`CHK("oe_n", 6'h3e, oe_n)
		wr(4'h0, 32'h3f000000);
		cyc(2);
		`CHK("oe_n", 6'h00, oe_n)
		`CHK("pins", 6'h15, pins)
		wr(4'h0, 32'h05000000);
		cyc(2);
		`CHK("pins", {6'h3a, 6'h05}, {oe_n, pins})
		wr(4'h0, 32'h8c000000);
		cyc(4);
		`CHK("oe_n", 6'h3a, oe_n)
		roll;
		cyc(2);
		`CHK("oe_n", 6'h33, oe_n)
		foreach (codes[i])
		begin
			@(posedge clk) sel <= codes[i];
			wr(4'h0, {13'h0, codes[i], 16'h0});
			cyc(5);
			n = caps;
			@(posedge clk) level <= 1'b1;
			cyc(8);
			@(posedge clk) level <= 1'b0;
			cyc(8);
			`CHK("captures", n + 1, caps)
		end
		@(posedge clk) sel <= 3'h0;
		gate(1'b0, 1'b1);
		n = caps;
		@(posedge clk) level <= 1'b1;
		cyc(8);
		`CHK("captures", n, caps)
		@(posedge clk) level <= 1'b0;
		wr(4'h0, 32'h00400000);
		gate(1'b1, 1'b0);
		gate(1'b0, 1'b0);
		wr(4'h0, 32'h00800000);
		gate(1'b1, 1'b0);
		gate(1'b0, 1'b1);
		gate(1'b1, 1'b1);
		wr(4'h0, 32'h00080000);
		n = auxn;
		roll;
		cyc(3);
		`CHK("aux_out", n + 1, auxn)
		wr(4'h0, 32'h00000000);
		roll;
		cyc(3);
		`CHK("aux_out", n + 1, auxn)
		wr(4'h0, 32'h00180000);
		@(posedge clk) compare_event <= 1'b1;
		@(posedge clk) compare_event <= 1'b0;
		cyc(3);
		`CHK("aux_out", n + 2, auxn)
		@(posedge clk) timer_mode <= 1'b1;
		@(posedge clk) compare_event <= 1'b1;
		@(posedge clk) compare_event <= 1'b0;
		cyc(3);
		`CHK("aux_out", n + 2, auxn)
		wr(4'h0, 32'h00100000);
		@(posedge clk) mode_signal <= 1'b1;
		cyc(3);
		`CHK("aux_out", 1'b1, aux_out)
		@(posedge clk) cedge <= 1'b0;
		n = caps;
		@(posedge clk) level <= 1'b1;
		cyc(8);
		`CHK("captures", n, caps)
		@(posedge clk) level <= 1'b0;
		cyc(8);
		`CHK("captures", n + 1, caps)
		wr(4'h3, 32'h0000000f);
		wr(4'h2, 32'h00000002);
		wr(4'h0, 32'h3f008001);
		sd(8'h01, 1'b1);
		`CHK("pins", {1'b1, 6'h00}, {irq, pins})
		rd(4'h1, 32'h00000002);
		sd(8'h00, 1'b1);
		roll;
		cyc(2);
		`CHK("shutdown_event_flag", 1'b0, shutdown_event_flag)
		wr(4'h3, 32'h00000002);
		cyc(2);
		`CHK("irq", 1'b0, irq)
		rd(4'h1, 32'h00000004);
		wr(4'h0, 32'h3f000001);
		sd(8'h02, 1'b0);
		sd(8'h01, 1'b1);
		sd(8'h00, 1'b1);
		roll;
		cyc(3);
		`CHK("shutdown_event_flag", 1'b1, shutdown_event_flag)
		@(posedge clk) shutdown_clear_sw <= 1'b1;
		@(posedge clk) shutdown_clear_sw <= 1'b0;
		cyc(3);
		`CHK("pins", {1'b0, 6'h15}, {shutdown_event_flag, pins})
		end_sim;
	end

	// hang guard, far beyond the few hundred cycles needed
	initial
	begin
		#400000;
		fails++;
		end_sim;
	end
endmodule : ccp_output_steer_capture_gating_tb
